// [hw/fps_sequencer.sv]
// Four-rail power sequencer core with filtered enables and open-drain outputs.
// Assumes all inputs are synchronous to i_clk and external pull-ups on every pin.
//
// Behaviour
// - Channel inputs cannot release outputs while master enable low.
// - Each channel follows its own input independently.
// - Release output only after its power-up delay.
// - Each channel has its own delay setting.
// - Master fall asserts outputs from four down to one.
// - Power-down spacing uses the shared delay setting.
// - Input low during power-down asserts output at once.
// - Remaining channels keep their original power-down slot.
// - Re-enable releases asserted outputs after own delay.
// - Re-enable leaves still-released outputs untouched.
// - Outputs drive low when asserted, float otherwise.
// - Pull bias pin low once supply is up.
// - Outputs held asserted until supply is established.
// - Enable pulses shorter than 600 ns ignored.
// - Output number maps to same-numbered input.
`timescale 1ns/10ps
`default_nettype none
`include "fps_defines.svh"

module fps_sequencer
  import fps_pkg::*;
#(
  parameter int CHANNELS = `FPS_CHANNELS,
  parameter int DELAY_W  = `FPS_DELAY_W
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_supply_ready,
  input  wire logic                        i_master_enable,
  input  wire logic [CHANNELS-1:0]         i_channel_monitor_input,
  input  wire logic [CHANNELS*DELAY_W-1:0] i_channel_delay_setting,
  input  wire logic [DELAY_W-1:0]          i_powerdown_delay_setting,
  input  wire logic [CHANNELS-1:0]         i_channel_sequenced_output_pin,
  input  wire logic                        i_all_rails_good_pin,
  input  wire logic                        i_bias_pin,
  output var  fps_od_s [CHANNELS-1:0]      o_channel_sequenced_output,
  output var  fps_od_s                     o_all_rails_good,
  output var  fps_od_s                     o_bias_pulldown
);

  localparam int PERIOD_NS   = `FPS_CLK_PERIOD_NS;
  localparam int FILT_CYCLES = (`FPS_FILTER_NS + PERIOD_NS - 1) / PERIOD_NS;
  localparam int TICK_CYCLES = `FPS_TICK_NS / PERIOD_NS;
  localparam int FILT_W      = $clog2(FILT_CYCLES + 1);
  localparam int TICK_W      = $clog2(TICK_CYCLES + 1);
  localparam int NRAW        = CHANNELS + 1;

  // The pin readbacks are kept for wire-OR visibility and are not needed here.
  logic unused_pins;
  assign unused_pins = ^{i_channel_sequenced_output_pin, i_all_rails_good_pin, i_bias_pin};

  logic                   held_off;
  logic                   tick;
  logic [TICK_W-1:0]      tick_count;
  logic [NRAW-1:0]        raw;
  logic [NRAW-1:0]        filt;
  logic                   master_f;
  logic                   master_d;
  logic [CHANNELS-1:0]    mon_f;
  logic [CHANNELS-1:0]    released;
  logic [CHANNELS-1:0]    next_released;
  logic [CHANNELS-1:0]    up_done;
  logic                   pd_hit;
  logic                   pd_run;
  logic [1:0]             pd_step;
  fps_pd_e                pd_state;

  // Logic is held in its reset state until the internal supply is up.
  assign held_off = i_reset || !i_supply_ready;
  assign raw      = {i_channel_monitor_input, i_master_enable};
  assign master_f = filt[0];
  assign mon_f    = filt[NRAW-1:1];

  // Divider that paces every delay counter.
  always_ff @(posedge i_clk) begin
    if (held_off) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == TICK_W'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + TICK_W'(1);
      tick       <= 1'b0;
    end
  end

  // A new input level is taken only after it has stood for the filter time.
  genvar gf;
  generate
    for (gf = 0; gf < NRAW; gf++) begin : g_filter
      logic [FILT_W-1:0] fcount;
      always_ff @(posedge i_clk) begin
        if (held_off) begin
          fcount       <= '0;
          filt[gf]     <= 1'b0;
        end else if (raw[gf] == filt[gf]) begin
          fcount       <= '0;
        end else if (fcount == FILT_W'(FILT_CYCLES - 1)) begin
          fcount       <= '0;
          filt[gf]     <= raw[gf];
        end else begin
          fcount       <= fcount + FILT_W'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (held_off) begin
      master_d <= 1'b0;
    end else begin
      master_d <= master_f;
    end
  end

  // Power-down sequencer: one shared slot timer steps from channel four down.
  assign pd_run = (pd_state == PD_RUN) && !master_f;

  fps_chan_timer #(
    .WIDTH      (DELAY_W)
  ) u_pd_timer (
    .i_clk      (i_clk),
    .i_reset    (held_off),
    .i_tick     (tick),
    .i_run      (pd_run),
    .i_clear    (pd_hit),
    .i_terminal (i_powerdown_delay_setting),
    .o_done     (pd_hit)
  );

  always_ff @(posedge i_clk) begin
    if (held_off) begin
      pd_state <= PD_IDLE;
      pd_step  <= 2'h0;
    end else begin
      case (pd_state)
        PD_IDLE: begin
          if (master_d && !master_f) begin
            pd_state <= PD_RUN;
            pd_step  <= 2'h0;
          end
        end
        PD_RUN: begin
          if (master_f) begin
            pd_state <= PD_IDLE;
          end else if (pd_hit) begin
            if (pd_step == `FPS_LAST_STEP) begin
              pd_state <= PD_DONE;
            end else begin
              pd_step <= pd_step + 2'h1;
            end
          end
        end
        PD_DONE: begin
          if (master_f) begin
            pd_state <= PD_IDLE;
          end
        end
        default: begin
          pd_state <= PD_IDLE;
        end
      endcase
    end
  end

  // Per-channel power-up timers and output decisions.
  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
      logic up_run;
      assign up_run = master_f && mon_f[gc] && !released[gc];

      fps_chan_timer #(
        .WIDTH      (DELAY_W)
      ) u_up_timer (
        .i_clk      (i_clk),
        .i_reset    (held_off),
        .i_tick     (tick),
        .i_run      (up_run),
        .i_clear    (1'b0),
        .i_terminal (i_channel_delay_setting[gc*DELAY_W +: DELAY_W]),
        .o_done     (up_done[gc])
      );

      always_comb begin
        next_released[gc] = released[gc];
        if (master_f) begin
          if (!mon_f[gc]) begin
            next_released[gc] = 1'b0;
          end else if (up_done[gc]) begin
            next_released[gc] = 1'b1;
          end
        end else if (pd_state == PD_RUN) begin
          if (!mon_f[gc]) begin
            next_released[gc] = 1'b0;
          end else if (pd_hit && (pd_step == 2'(CHANNELS - 1 - gc))) begin
            next_released[gc] = 1'b0;
          end
        end else if (pd_state == PD_DONE) begin
          next_released[gc] = 1'b0;
        end
      end

      always_ff @(posedge i_clk) begin
        if (held_off) begin
          released[gc]                      <= 1'b0;
          o_channel_sequenced_output[gc].oe <= 1'b1;
        end else begin
          released[gc]                      <= next_released[gc];
          o_channel_sequenced_output[gc].oe <= !next_released[gc];
        end
      end

      always_ff @(posedge i_clk) begin
        o_channel_sequenced_output[gc].o <= 1'b0;
      end

      sequence s_drop_early;
        (pd_state == PD_RUN) && !master_f && !mon_f[gc];
      endsequence

      a_monitor_low_drop: assert property (@(posedge i_clk) disable iff (held_off)
        master_f && !mon_f[gc] |=> !released[gc])
        else $error("channel stayed released with its input low");

      a_release_cause: assert property (@(posedge i_clk) disable iff (held_off)
        $rose(released[gc]) |-> $past(up_done[gc]) && $past(master_f) && $past(mon_f[gc]))
        else $error("channel released without enable and elapsed delay");

      a_early_drop: assert property (@(posedge i_clk) disable iff (held_off)
        s_drop_early |=> !released[gc] && o_channel_sequenced_output[gc].oe)
        else $error("channel not dropped at once during power-down");

      a_reenable_keep: assert property (@(posedge i_clk) disable iff (held_off)
        (pd_state == PD_RUN) && master_f && mon_f[gc] && released[gc] |=> released[gc])
        else $error("released channel interrupted by re-enable");

      a_input_filter: assert property (@(posedge i_clk) disable iff (held_off)
        $changed(mon_f[gc]) |-> $past(i_channel_monitor_input[gc], 8) == mon_f[gc])
        else $error("channel input acted on before filter time");
    end
  endgenerate

  // Power good follows all channels; bias pin is pulled low once supply is up.
  always_ff @(posedge i_clk) begin
    if (held_off) begin
      o_all_rails_good.oe <= 1'b1;
    end else begin
      o_all_rails_good.oe <= !(&next_released);
    end
  end

  always_ff @(posedge i_clk) begin
    o_all_rails_good.o <= 1'b0;
    o_bias_pulldown.o  <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_bias_pulldown.oe <= 1'b0;
    end else begin
      o_bias_pulldown.oe <= i_supply_ready;
    end
  end

  sequence s_slot_end(int step);
    pd_run && pd_hit && (pd_step == 2'(step));
  endsequence

  a_master_low_ignore: assert property (@(posedge i_clk) disable iff (held_off)
    (pd_state == PD_DONE) && !master_f |-> released == '0)
    else $error("channel released while master enable low");

  a_first_slot_ch4: assert property (@(posedge i_clk) disable iff (held_off)
    s_slot_end(0) |=> !released[CHANNELS-1])
    else $error("channel four not asserted in first slot");

  a_last_slot_ch1: assert property (@(posedge i_clk) disable iff (held_off)
    s_slot_end(3) |=> !released[0] && (pd_state == PD_DONE))
    else $error("channel one not asserted in last slot");

  a_reverse_order: assert property (@(posedge i_clk) disable iff (held_off)
    $fell(released[0]) && $past(pd_run) && $past(mon_f[0]) |-> released[CHANNELS-1:1] == '0)
    else $error("channel one asserted before higher channels");

  a_slot_spacing: assert property (@(posedge i_clk) disable iff (held_off)
    pd_run && pd_hit && (i_powerdown_delay_setting != '0) |=> !pd_hit)
    else $error("power-down slots closer than the shared delay");

  a_power_good: assert property (@(posedge i_clk) disable iff (held_off)
    o_all_rails_good.oe == !(&released))
    else $error("power good disagrees with channel outputs");

  a_reset_asserts: assert property (@(posedge i_clk)
    i_reset |=> (released == '0) && o_all_rails_good.oe)
    else $error("outputs not asserted after reset");

  a_supply_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_supply_ready |=> (released == '0) && o_all_rails_good.oe && !o_bias_pulldown.oe)
    else $error("outputs not held while supply is absent");

  a_bias_pulldown: assert property (@(posedge i_clk) disable iff (i_reset)
    i_supply_ready [*2] |-> o_bias_pulldown.oe)
    else $error("bias pin not pulled down with supply up");

endmodule

`default_nettype wire

// [inc/fps_defines.svh]
// Timing constants for the four-rail power sequencer.
// Assumes a single system clock; included by the package and the design files.
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_CLK_PERIOD_NS 40
`define FPS_FILTER_NS     600
`define FPS_TICK_NS       1000
`define FPS_DELAY_W       21
`define FPS_CHANNELS      4
`define FPS_LAST_STEP     2'h3

`endif

// [inc/fps_pkg.sv]
// Types shared by the four-rail power sequencer files.
// Assumes fps_defines.svh is reachable on the include path.
`include "fps_defines.svh"

package fps_pkg;

  // One open-drain pin as driven by the design: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } fps_od_s;

  typedef logic [`FPS_DELAY_W-1:0] fps_delay_t;

  typedef enum logic [1:0] {
    PD_IDLE = 2'b00,
    PD_RUN  = 2'b01,
    PD_DONE = 2'b10
  } fps_pd_e;

endpackage

// [hw/fps_chan_timer.sv]
// Delay counter that counts divider ticks up to a terminal count.
// Assumes i_tick is a one-cycle enable pulse from the parent's divider.
`timescale 1ns/10ps
`default_nettype none
`include "fps_defines.svh"

module fps_chan_timer
  import fps_pkg::*;
#(
  parameter int WIDTH = `FPS_DELAY_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_tick,
  input  wire logic             i_run,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_terminal,
  output logic                  o_done
);

  logic [WIDTH-1:0] count;

  // The count restarts from zero whenever the run condition drops.
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_run || i_clear) begin
      count <= '0;
    end else if (i_tick && (count < i_terminal)) begin
      count <= count + WIDTH'(1);
    end
  end

  assign o_done = i_run && (count >= i_terminal);

endmodule

`default_nettype wire

// [tb/fps_rail_load.sv]
// Pull-up load on the sequencer's open-drain pins, resolving each wire level.
// Assumes a pull-up on every output pin and a supply resistor on the bias pin.
`timescale 1ns/10ps
`default_nettype none

module fps_rail_load
  import fps_pkg::*;
(
  input  wire fps_od_s [3:0] i_chan,
  input  wire fps_od_s       i_good,
  input  wire fps_od_s       i_bias,
  output logic [3:0]         o_chan_pin,
  output logic               o_good_pin,
  output logic               o_bias_pin
);
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_chan_pin[k] = i_chan[k].oe ? i_chan[k].o : 1'b1;
    end
    o_good_pin = i_good.oe ? i_good.o : 1'b1;
    o_bias_pin = i_bias.oe ? i_bias.o : 1'b1;
  end
endmodule

`default_nettype wire

// [tb/four_rail_power_sequencer_tb.sv]
// Self-checking bench for the four-rail power sequencer.
// Assumes fps_pkg and the pull-up load model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module four_rail_power_sequencer_tb;
  import fps_pkg::*;
  localparam int TICK = 25;
  localparam int FILT = 15;
  localparam int PD   = 2;
  logic          i_clk      = 1'b0;
  logic          i_reset    = 1'b1;
  logic          sup        = 1'b0;
  logic          men        = 1'b0;
  logic [3:0]    mon        = 4'h0;
  fps_od_s [3:0] ch_od;
  fps_od_s       pg_od;
  fps_od_s       bias_od;
  logic [3:0]    ch_pin;
  logic          pg_pin;
  logic          bias_pin;
  logic [4:0]    oe_v;
  logic [4:0]    oe_q       = 5'h1f;
  int            cyc        = 0;
  int            ta[5];
  int            tr[5];
  int            n_mismatch = 0;
  int            n_checks   = 0;
  event          trk_ev;

  always #20 i_clk = ~i_clk;

  fps_sequencer dut_u (
    .i_clk                          (i_clk),
    .i_reset                        (i_reset),
    .i_supply_ready                 (sup),
    .i_master_enable                (men),
    .i_channel_monitor_input        (mon),
    .i_channel_delay_setting        ({21'h0_0004, 21'h0_0003, 21'h0_0002, 21'h0_0001}),
    .i_powerdown_delay_setting      (21'h0_0002),
    .i_channel_sequenced_output_pin (ch_pin),
    .i_all_rails_good_pin           (pg_pin),
    .i_bias_pin                     (bias_pin),
    .o_channel_sequenced_output     (ch_od),
    .o_all_rails_good               (pg_od),
    .o_bias_pulldown                (bias_od)
  );

  fps_rail_load load_u (
    .i_chan     (ch_od),
    .i_good     (pg_od),
    .i_bias     (bias_od),
    .o_chan_pin (ch_pin),
    .o_good_pin (pg_pin),
    .o_bias_pin (bias_pin)
  );

  assign oe_v = {pg_od.oe, ch_od[3].oe, ch_od[2].oe, ch_od[1].oe, ch_od[0].oe};

  // Edge times of the four channel enables and power good, index 4 being power good.
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(negedge i_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (oe_v[k] === 1'b1 && oe_q[k] !== 1'b1) ta[k] = cyc;
      if (oe_v[k] === 1'b0 && oe_q[k] !== 1'b0) tr[k] = cyc;
    end
    oe_q = oe_v;
    // Waiters resume on this event so edge times are recorded before they are read.
    -> trk_ev;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    n_checks++;
    if (v < lo || v > hi) begin
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
      n_mismatch++;
    end
  endtask

  task automatic wait_oe(input int k, input logic lvl, input int lim);
    int n;
    n = 0;
    while (oe_v[k] !== lvl && n < lim) begin
      @(trk_ev);
      n++;
    end
    chk("enable wait", 32'(lvl), 32'(oe_v[k]));
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic t_powerup(input int t0);
    wait_oe(4, 1'b0, 300);
    for (int k = 0; k < 4; k++) begin
      rng("release time", t0 + k*TICK + FILT, t0 + (k+1)*TICK + FILT + 10, tr[k]);
    end
    chk("good with last", 32'(tr[3]), 32'(tr[4]));
    chk("pins high", 32'h0000_000f, 32'(ch_pin));
  endtask

  task automatic t_chan_drop;
    int t0;
    mon[1] = 1'b0;
    t0 = cyc;
    repeat (30) @(negedge i_clk);
    rng("drop time", t0 + FILT, t0 + FILT + 3, ta[1]);
    chk("only chan 2", 32'h0000_0012, 32'(oe_v));
    mon[1] = 1'b1;
    t0 = cyc;
    wait_oe(1, 1'b0, 200);
    rng("restart", t0 + TICK + FILT, t0 + 2*TICK + FILT + 10, tr[1]);
  endtask

  task automatic t_glitch;
    men = 1'b0;
    mon[2] = 1'b0;
    repeat (10) @(negedge i_clk);
    men = 1'b1;
    mon[2] = 1'b1;
    repeat (100) @(negedge i_clk);
    chk("glitch ignored", 32'h0, 32'(oe_v));
  endtask

  task automatic t_powerdown;
    int t0;
    men = 1'b0;
    t0 = cyc;
    wait_oe(0, 1'b1, 600);
    rng("first slot", t0 + FILT + (PD-1)*TICK, t0 + FILT + PD*TICK + 10, ta[3]);
    for (int k = 2; k >= 0; k--) begin
      rng("slot gap", ta[k+1] + (PD-1)*TICK, ta[k+1] + PD*TICK + 5, ta[k]);
    end
    rng("good drop", ta[3], ta[3] + 1, ta[4]);
  endtask

  task automatic t_abort;
    int t1;
    men = 1'b0;
    wait_oe(3, 1'b1, 200);
    mon[0] = 1'b0;
    t1 = cyc;
    wait_oe(0, 1'b1, 40);
    rng("early drop", t1 + FILT, t1 + FILT + 3, ta[0]);
    wait_oe(1, 1'b1, 300);
    rng("kept slot 3", ta[3] + (PD-1)*TICK, ta[3] + PD*TICK + 5, ta[2]);
    rng("kept slot 2", ta[2] + (PD-1)*TICK, ta[2] + PD*TICK + 5, ta[1]);
    mon[0] = 1'b1;
    repeat (20) @(negedge i_clk);
  endtask

  task automatic t_reenable;
    int t0;
    int sv[3];
    men = 1'b0;
    wait_oe(3, 1'b1, 200);
    men = 1'b1;
    t0 = cyc;
    sv = '{ta[0], ta[1], ta[2]};
    wait_oe(3, 1'b0, 300);
    rng("re-release", t0 + 3*TICK + FILT, t0 + 4*TICK + FILT + 10, tr[3]);
    repeat (150) @(negedge i_clk);
    chk("others kept", 32'h0, 32'(oe_v));
    for (int k = 0; k < 3; k++) chk("no blip", sv[k], ta[k]);
  endtask

  initial begin
    repeat (5) @(negedge i_clk);
    chk("reset state", 32'h0000_001f, 32'(oe_v));
    chk("pins low", 32'h0, 32'({pg_pin, ch_pin}));
    chk("bias idle", 32'h0, 32'(bias_od.oe));
    sup = 1'b1;
    repeat (5) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("bias pulled", 32'h0, 32'(bias_pin));
    mon = 4'hf;
    repeat (200) @(negedge i_clk);
    chk("master gates", 32'h0000_001f, 32'(oe_v));
    men = 1'b1;
    t_powerup(cyc);
    t_chan_drop();
    t_glitch();
    t_powerdown();
    men = 1'b1;
    t_powerup(cyc);
    t_abort();
    men = 1'b1;
    t_powerup(cyc);
    t_reenable();
    sup = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("undervoltage", 32'h0000_001f, 32'(oe_v));
    chk("bias released", 32'h0, 32'(bias_od.oe));
    sup = 1'b1;
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    t_powerup(cyc);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule

`default_nettype wire
